/* File: verilog/mtxc_regs.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef MTXC_REGS_SVH
`define MTXC_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define MTXC_TX_CFG_OFS 8'h40
`define MTXC_RX_CFG_OFS 8'h44
`define MTXC_EE_CMD_OFS 8'h50
`define MTXC_CFG0_OFS 8'h51
`define MTXC_CFG1_OFS 8'h52
`define MTXC_CFG2_OFS 8'h53

// ==========================================================
// Transmit configuration fields
`define MTXC_TX_GAP_BIT 19
`define MTXC_TX_LBK_LO 17
`define MTXC_TX_NOFCS_BIT 16
`define MTXC_DMA_LO 8
`define MTXC_TX_WR_MASK 32'h000f_0700
`define MTXC_TX_RESET 32'h0000_0000

// ==========================================================
// Receive configuration fields
`define MTXC_RX_MULTI_BIT 24
`define MTXC_RX_SHORTCRC_BIT 16
`define MTXC_RX_FTH_LO 13
`define MTXC_RX_EESZ_BIT 6
`define MTXC_RX_AER_BIT 5
`define MTXC_RX_AR_BIT 4
`define MTXC_RX_AB_BIT 3
`define MTXC_RX_AM_BIT 2
`define MTXC_RX_APM_BIT 1
`define MTXC_RX_AAP_BIT 0
`define MTXC_RX_WR_MASK 32'h0101_e73f
`define MTXC_RX_RESET 32'h0000_0000

// ==========================================================
// Command and config byte fields
`define MTXC_CMD_MODE_LO 6
`define MTXC_CMD_CS_BIT 3
`define MTXC_CMD_SK_BIT 2
`define MTXC_CMD_DI_BIT 1
`define MTXC_CMD_DO_BIT 0
`define MTXC_CFG1_WR_MASK 8'hf3
`define MTXC_CFG1_RESET 8'h00
`define MTXC_CFG2_AUX_BIT 4
`define MTXC_CFG2_WIDTH_BIT 3

// ==========================================================
// Frame lengths and timing
`define MTXC_RUNT_MIN_BYTES 16'd8
`define MTXC_FRAME_MIN_BYTES 16'd64
`define MTXC_RX_RSVD_BELOW 3'h2
`define MTXC_TX_RSVD_BELOW 3'h0
`define MTXC_AUTOLOAD_MS 2
`define MTXC_CLK_KHZ 50000

`endif

/* File: verilog/mtxc_pkg.sv */
// Types shared by the MAC configuration register bank
package mtxc_pkg;

	typedef enum logic [1:0] {
		MTXC_MODE_NORMAL = 2'b00,
		MTXC_MODE_AUTOLOAD = 2'b01,
		MTXC_MODE_PROGRAM = 2'b10,
		MTXC_MODE_CFG_WRITE = 2'b11
	} mtxc_mode_t;

	typedef enum logic [1:0] {
		MTXC_LBK_NORMAL = 2'b00,
		MTXC_LBK_DIGITAL = 2'b01
	} mtxc_lbk_t;

	typedef enum logic [1:0] {
		MTXC_ST_RUN = 2'b00,
		MTXC_ST_LOAD = 2'b01,
		MTXC_ST_DONE = 2'b11
	} mtxc_state_t;

endpackage

/* File: verilog/mtxc_burst_dec.sv */
// Decoder for the doubling burst-size and threshold codes
`timescale 1ns/10ps

module mtxc_burst_dec #(
	parameter logic [2:0] RSVD_BELOW = 3'h0
) (
	input wire logic [2:0] code,
	output logic [10:0] bytes,
	output logic unlimited,
	output logic reserved
);

	// Code 0 is 16 bytes and each step doubles; top code has no limit
	assign unlimited = (code == 3'h7);
	assign reserved = (code < RSVD_BELOW);
	assign bytes = (unlimited || reserved) ? 11'h000 : (11'h010 << code);

endmodule

/* File: verilog/mtxc_top.sv */
// MAC transmit/receive configuration, EEPROM command and config bytes
`timescale 1ns/10ps
`include "mtxc_regs.svh"

// Summary of operation
// - Loopback code 00 normal, 01 digital with media transmit silenced.
// - No-FCS bit 16 set omits CRC on transmit; clear appends it.
// - Tx burst code doubles from 16 to 1024 bytes; 111 unlimited.
// - Multi early interrupt bit 24 requests early interrupt per packet.
// - Short CRC bit: check above 8 bytes, otherwise above 64 bytes.
// - Accept-error or accept-runt forces CRC check above 8 bytes.
// - Rx threshold code 010..110 gives 64..1024 bytes; 000, 001 reserved.
// - Threshold code 111 waits for the whole packet before transfer.
// - Rx burst code 010..110 gives 64..1024 bytes, 111 unlimited.
// - Read-only bit 6 shows the larger EEPROM part is fitted.
// - Accept-error keeps CRC, alignment and collision packets; else drop.
// - Accept-runt keeps packets under 64 bytes but at least 8.
// - Broadcast, multicast, physical and all-address filters act alone.
// - Mode 01 reloads for about 2 ms, then mode 00 and defaults.
// - Mode 10 halts network and gives software the EEPROM pins.
// - Protected config writes land only while the mode field is 11.
module mtxc_top #(
	parameter int AUTOLOAD_CYCLES = `MTXC_AUTOLOAD_MS * `MTXC_CLK_KHZ
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata_r,
	input wire logic transmit_enable,
	input wire logic strap_eeprom_large,
	input wire logic [2:0] strap_boot_rom_size,
	input wire logic strap_aux_power,
	input wire logic strap_bus_64bit,
	input wire logic [2:0] strap_bus_clk_freq,
	input wire logic [1:0] strap_reg_map,
	input wire logic eeprom_data_out,
	output logic eeprom_chip_select_r,
	output logic eeprom_serial_clock_r,
	output logic eeprom_data_in_r,
	output mtxc_pkg::mtxc_mode_t operating_mode_field_r,
	output logic autoload_busy_r,
	output logic net_disable_r,
	output logic loopback_digital_r,
	output logic tx_media_enable_r,
	output logic tx_append_fcs_r,
	output logic [10:0] tx_burst_bytes_r,
	output logic tx_burst_unlimited_r,
	output logic multi_early_irq_enable_r,
	output logic [10:0] rx_threshold_bytes_r,
	output logic rx_whole_packet_r,
	output logic [10:0] rx_burst_bytes_r,
	output logic rx_burst_unlimited_r,
	input wire logic rx_pkt_valid,
	input wire logic [15:0] rx_pkt_len,
	input wire logic rx_crc_err,
	input wire logic rx_align_err,
	input wire logic rx_collided,
	input wire logic rx_dst_bcast,
	input wire logic rx_dst_mcast,
	input wire logic rx_dst_phys,
	output logic rx_pkt_done_r,
	output logic rx_pkt_accept_r,
	output logic rx_crc_checked_r
);
	import mtxc_pkg::*;

	// ==========================================================
	// State
	logic [31:0] tx_cfg_r;
	logic [31:0] rx_cfg_r;
	logic [2:0] ee_pins_r;
	logic [7:0] cfg1_r;
	logic straps_caught_r;
	logic eeprom_large_r;
	logic [2:0] boot_rom_size_r;
	logic aux_power_r;
	logic bus_64bit_r;
	logic [2:0] bus_clk_freq_r;
	logic [1:0] reg_map_r;
	mtxc_state_t state_r;
	mtxc_state_t state_nxt;
	logic [31:0] load_cnt_r;

	// ==========================================================
	// Address decode
	wire hit_tx = (reg_addr == `MTXC_TX_CFG_OFS);
	wire hit_rx = (reg_addr == `MTXC_RX_CFG_OFS);
	wire hit_cw = (reg_addr == `MTXC_EE_CMD_OFS);
	wire loading = (state_r != MTXC_ST_RUN);
	wire wr_ok = reg_wr && !loading;
	wire [31:0] be_mask = {{8{reg_be[3]}}, {8{reg_be[2]}},
		{8{reg_be[1]}}, {8{reg_be[0]}}};

	// Transmit config is only accepted once the transmitter is on
	wire wr_tx = wr_ok && hit_tx && transmit_enable;
	wire wr_rx = wr_ok && hit_rx;
	wire wr_cmd = wr_ok && hit_cw && reg_be[0];
	wire wr_cfg1 = wr_ok && hit_cw && reg_be[2] &&
		(operating_mode_field_r == MTXC_MODE_CFG_WRITE);

	wire [31:0] tx_mask = be_mask & `MTXC_TX_WR_MASK;
	wire [31:0] rx_mask = be_mask & `MTXC_RX_WR_MASK;
	wire [31:0] tx_cfg_nxt = (tx_cfg_r & ~tx_mask) | (reg_wdata & tx_mask);
	wire [31:0] rx_cfg_nxt = (rx_cfg_r & ~rx_mask) | (reg_wdata & rx_mask);
	wire [7:0] cfg1_nxt = (cfg1_r & ~`MTXC_CFG1_WR_MASK) |
		(reg_wdata[23:16] & `MTXC_CFG1_WR_MASK);
	wire [1:0] mode_wr = reg_wdata[`MTXC_CMD_MODE_LO +: 2];
	wire start_load = wr_cmd && (mode_wr == MTXC_MODE_AUTOLOAD);
	wire prog_mode = (operating_mode_field_r == MTXC_MODE_PROGRAM);

	// ==========================================================
	// Field views
	wire [1:0] lbk = tx_cfg_r[`MTXC_TX_LBK_LO +: 2];
	wire [2:0] tx_dma = tx_cfg_r[`MTXC_DMA_LO +: 3];
	wire [2:0] rx_dma = rx_cfg_r[`MTXC_DMA_LO +: 3];
	wire [2:0] rx_fth = rx_cfg_r[`MTXC_RX_FTH_LO +: 3];
	wire accept_error = rx_cfg_r[`MTXC_RX_AER_BIT];
	wire ar = rx_cfg_r[`MTXC_RX_AR_BIT];

	// ==========================================================
	// Code decoders
	logic [10:0] tx_bytes;
	logic tx_unl;
	logic [10:0] rx_bytes;
	logic rx_unl;
	logic [10:0] fth_bytes;
	logic fth_whole;

	mtxc_burst_dec #(.RSVD_BELOW(`MTXC_TX_RSVD_BELOW)) u_tx_burst (
		.code(tx_dma),
		.bytes(tx_bytes),
		.unlimited(tx_unl),
		.reserved()
	);

	mtxc_burst_dec #(.RSVD_BELOW(`MTXC_RX_RSVD_BELOW)) u_rx_burst (
		.code(rx_dma),
		.bytes(rx_bytes),
		.unlimited(rx_unl),
		.reserved()
	);

	mtxc_burst_dec #(.RSVD_BELOW(`MTXC_RX_RSVD_BELOW)) u_rx_fth (
		.code(rx_fth),
		.bytes(fth_bytes),
		.unlimited(fth_whole),
		.reserved()
	);

	// ==========================================================
	// Receive packet filter
	wire long_check = rx_cfg_r[`MTXC_RX_SHORTCRC_BIT] || accept_error || ar;
	wire crc_checked = long_check ?
		(rx_pkt_len > `MTXC_RUNT_MIN_BYTES) :
		(rx_pkt_len > `MTXC_FRAME_MIN_BYTES);
	wire bad_frame = (crc_checked && rx_crc_err) || rx_align_err ||
		rx_collided;
	wire err_ok = !bad_frame || accept_error;
	wire len_ok = (rx_pkt_len >= `MTXC_RUNT_MIN_BYTES) &&
		((rx_pkt_len >= `MTXC_FRAME_MIN_BYTES) || ar);
	wire dst_ok = rx_cfg_r[`MTXC_RX_AAP_BIT] ||
		(rx_dst_bcast && rx_cfg_r[`MTXC_RX_AB_BIT]) ||
		(rx_dst_mcast && !rx_dst_bcast && rx_cfg_r[`MTXC_RX_AM_BIT]) ||
		(rx_dst_phys && rx_cfg_r[`MTXC_RX_APM_BIT]);
	// Network is off while software owns the EEPROM or a reload runs
	wire net_off = prog_mode || loading;
	wire pkt_accept = dst_ok && err_ok && len_ok && !net_off;

	// ==========================================================
	// Read mux
	wire [31:0] tx_view = tx_cfg_r & `MTXC_TX_WR_MASK;
	wire [31:0] rx_view = (rx_cfg_r & `MTXC_RX_WR_MASK) |
		({31'h0, eeprom_large_r} << `MTXC_RX_EESZ_BIT);
	wire [7:0] cmd_view = {operating_mode_field_r, 2'b00, ee_pins_r,
		eeprom_data_out};
	wire [7:0] cfg0_view = {5'h00, boot_rom_size_r};
	wire [7:0] cfg1_view = {cfg1_r[7:4], reg_map_r, cfg1_r[1:0]};
	wire [7:0] cfg2_view = {3'h0, aux_power_r, bus_64bit_r,
		bus_clk_freq_r};
	wire [31:0] rd_data = hit_tx ? tx_view :
		hit_rx ? rx_view :
		hit_cw ? ({cfg2_view, cfg1_view, cfg0_view, cmd_view} & be_mask) :
		32'h0000_0000;

	// ==========================================================
	// Reload sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			MTXC_ST_RUN: begin
				if (start_load) begin
					state_nxt = MTXC_ST_LOAD;
				end
			end
			MTXC_ST_LOAD: begin
				if (load_cnt_r == 32'(AUTOLOAD_CYCLES - 1)) begin
					state_nxt = MTXC_ST_DONE;
				end
			end
			MTXC_ST_DONE: begin
				state_nxt = MTXC_ST_RUN;
			end
			default: begin
				state_nxt = MTXC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= MTXC_ST_RUN;
			load_cnt_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			load_cnt_r <= (state_r == MTXC_ST_LOAD) ? load_cnt_r + 32'h1 :
				32'h0;
		end
	end

	// ==========================================================
	// Registers; reload end restores all defaults and mode 00
	wire load_end = (state_r == MTXC_ST_DONE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cfg_r <= `MTXC_TX_RESET;
			rx_cfg_r <= `MTXC_RX_RESET;
			cfg1_r <= `MTXC_CFG1_RESET;
			ee_pins_r <= 3'h0;
			operating_mode_field_r <= MTXC_MODE_NORMAL;
		end else if (load_end) begin
			tx_cfg_r <= `MTXC_TX_RESET;
			rx_cfg_r <= `MTXC_RX_RESET;
			cfg1_r <= `MTXC_CFG1_RESET;
			ee_pins_r <= 3'h0;
			operating_mode_field_r <= MTXC_MODE_NORMAL;
		end else begin
			if (wr_tx) begin
				tx_cfg_r <= tx_cfg_nxt;
			end
			if (wr_rx) begin
				rx_cfg_r <= rx_cfg_nxt;
			end
			if (wr_cfg1) begin
				cfg1_r <= cfg1_nxt;
			end
			if (wr_cmd) begin
				operating_mode_field_r <= mtxc_mode_t'(mode_wr);
				ee_pins_r <= reg_wdata[`MTXC_CMD_CS_BIT:`MTXC_CMD_DI_BIT];
			end
		end
	end

	// Straps are caught by the first clock after bus reset, never again
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			straps_caught_r <= 1'b0;
			eeprom_large_r <= 1'b0;
			boot_rom_size_r <= 3'h0;
			aux_power_r <= 1'b0;
			bus_64bit_r <= 1'b0;
			bus_clk_freq_r <= 3'h0;
			reg_map_r <= 2'h0;
		end else if (!straps_caught_r) begin
			straps_caught_r <= 1'b1;
			eeprom_large_r <= strap_eeprom_large;
			boot_rom_size_r <= strap_boot_rom_size;
			aux_power_r <= strap_aux_power;
			bus_64bit_r <= strap_bus_64bit;
			bus_clk_freq_r <= strap_bus_clk_freq;
			reg_map_r <= strap_reg_map;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 32'h0;
			eeprom_chip_select_r <= 1'b0;
			eeprom_serial_clock_r <= 1'b0;
			eeprom_data_in_r <= 1'b0;
			autoload_busy_r <= 1'b0;
			net_disable_r <= 1'b0;
			loopback_digital_r <= 1'b0;
			tx_media_enable_r <= 1'b0;
			tx_append_fcs_r <= 1'b1;
			tx_burst_bytes_r <= 11'h0;
			tx_burst_unlimited_r <= 1'b0;
			multi_early_irq_enable_r <= 1'b0;
			rx_threshold_bytes_r <= 11'h0;
			rx_whole_packet_r <= 1'b0;
			rx_burst_bytes_r <= 11'h0;
			rx_burst_unlimited_r <= 1'b0;
			rx_pkt_done_r <= 1'b0;
			rx_pkt_accept_r <= 1'b0;
			rx_crc_checked_r <= 1'b0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_data : reg_rdata_r;
			// Pins follow software only in programming mode
			eeprom_chip_select_r <= prog_mode && ee_pins_r[2];
			eeprom_serial_clock_r <= prog_mode && ee_pins_r[1];
			eeprom_data_in_r <= prog_mode && ee_pins_r[0];
			autoload_busy_r <= loading;
			net_disable_r <= net_off;
			loopback_digital_r <= (lbk == MTXC_LBK_DIGITAL);
			// Reserved loopback codes leave the media path running
			tx_media_enable_r <= (lbk != MTXC_LBK_DIGITAL) &&
				!net_off;
			tx_append_fcs_r <= !tx_cfg_r[`MTXC_TX_NOFCS_BIT];
			tx_burst_bytes_r <= tx_bytes;
			tx_burst_unlimited_r <= tx_unl;
			multi_early_irq_enable_r <= rx_cfg_r[`MTXC_RX_MULTI_BIT];
			rx_threshold_bytes_r <= fth_bytes;
			rx_whole_packet_r <= fth_whole;
			rx_burst_bytes_r <= rx_bytes;
			rx_burst_unlimited_r <= rx_unl;
			rx_pkt_done_r <= rx_pkt_valid;
			rx_pkt_accept_r <= rx_pkt_valid && pkt_accept;
			rx_crc_checked_r <= rx_pkt_valid && crc_checked;
		end
	end

endmodule

/* File: bench/mtxc_top_properties.sv */
// Checker of port-level timing for the MAC configuration register bank
`timescale 1ns/10ps
`include "mtxc_regs.svh"
module mtxc_top_props #(
	parameter int AUTOLOAD_CYCLES = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic transmit_enable,
	input wire mtxc_pkg::mtxc_mode_t operating_mode_field_r,
	input wire logic autoload_busy_r,
	input wire logic eeprom_chip_select_r,
	input wire logic eeprom_serial_clock_r,
	input wire logic eeprom_data_in_r,
	input wire logic net_disable_r,
	input wire logic loopback_digital_r,
	input wire logic tx_media_enable_r,
	input wire logic tx_append_fcs_r,
	input wire logic [10:0] rx_threshold_bytes_r,
	input wire logic rx_whole_packet_r,
	input wire logic rx_pkt_valid,
	input wire logic [15:0] rx_pkt_len,
	input wire logic rx_pkt_done_r,
	input wire logic rx_pkt_accept_r
);
	import mtxc_pkg::*;
	int busy_cnt;
	// ==========================================================
	// Reload length counter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= autoload_busy_r ? busy_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Properties
	chk_done_follows_valid: assert property (rx_pkt_valid |=> rx_pkt_done_r)
		else $error("packet result missing");
	chk_runt_dropped: assert property (rx_pkt_valid &&
		rx_pkt_len < `MTXC_RUNT_MIN_BYTES |=> !rx_pkt_accept_r)
		else $error("short fragment accepted");
	chk_prog_rejects: assert property (rx_pkt_valid &&
		operating_mode_field_r == MTXC_MODE_PROGRAM |=> !rx_pkt_accept_r)
		else $error("packet accepted in programming mode");
	chk_pins_idle: assert property
		((operating_mode_field_r != MTXC_MODE_PROGRAM)[*2] |->
		!(eeprom_chip_select_r | eeprom_serial_clock_r | eeprom_data_in_r))
		else $error("eeprom pins driven outside programming");
	chk_net_off_prog: assert property
		((operating_mode_field_r == MTXC_MODE_PROGRAM)[*2] |-> net_disable_r)
		else $error("network not halted in programming");
	chk_lbk_silences: assert property
		(loopback_digital_r |-> !tx_media_enable_r)
		else $error("media active in digital loopback");
	chk_tx_gated: assert property (reg_wr &&
		reg_addr == `MTXC_TX_CFG_OFS && !transmit_enable && !autoload_busy_r
		&& operating_mode_field_r != MTXC_MODE_AUTOLOAD
		|=> ##1 $stable(tx_append_fcs_r))
		else $error("transmit config changed while disabled");
	chk_reload_start: assert property (reg_wr &&
		reg_addr == `MTXC_EE_CMD_OFS && reg_be[0] && reg_wdata[7:6] == 2'b01
		&& operating_mode_field_r != MTXC_MODE_AUTOLOAD
		|=> operating_mode_field_r == MTXC_MODE_AUTOLOAD ##1 autoload_busy_r)
		else $error("reload did not start");
	chk_reload_bound: assert property (busy_cnt <= AUTOLOAD_CYCLES + 2)
		else $error("reload too long");
	chk_reload_end: assert property ($fell(autoload_busy_r) |->
		operating_mode_field_r == MTXC_MODE_NORMAL && tx_append_fcs_r)
		else $error("reload did not restore defaults");
	chk_whole_pkt: assert property
		(rx_whole_packet_r |-> rx_threshold_bytes_r == 11'h000)
		else $error("threshold set with whole packet mode");
	cover property ($rose(autoload_busy_r));
	cover property (rx_pkt_done_r && rx_pkt_accept_r);
	cover property (loopback_digital_r);
endmodule
bind mtxc_top mtxc_top_props #(.AUTOLOAD_CYCLES(AUTOLOAD_CYCLES)) u_props (
	.core_clk, .rst_n, .reg_addr, .reg_be, .reg_wr, .reg_wdata,
	.transmit_enable, .operating_mode_field_r, .autoload_busy_r,
	.eeprom_chip_select_r, .eeprom_serial_clock_r, .eeprom_data_in_r,
	.net_disable_r, .loopback_digital_r, .tx_media_enable_r,
	.tx_append_fcs_r, .rx_threshold_bytes_r, .rx_whole_packet_r,
	.rx_pkt_valid, .rx_pkt_len, .rx_pkt_done_r, .rx_pkt_accept_r);

/* File: bench/mac_txrx_config_regs_bench.sv */
// Self-checking bench of the MAC configuration register bank
`timescale 1ns/10ps
`include "mtxc_regs.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module mac_txrx_config_regs_bench;
	import mtxc_pkg::*;
	typedef struct packed {
		logic [31:0] cfg;
		logic [15:0] len;
		logic [5:0] fl;
		logic acc;
		logic crc;
	} mtxc_row_t;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic transmit_enable = 1, strap_eeprom_large = 1, strap_aux_power = 1;
	logic strap_bus_64bit = 0, eeprom_data_out = 1, rx_pkt_valid = 0;
	logic rx_crc_err = 0, rx_align_err = 0, rx_collided = 0;
	logic rx_dst_bcast = 0, rx_dst_mcast = 0, rx_dst_phys = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [3:0] reg_be = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata_r;
	logic [2:0] strap_boot_rom_size = 3'h5, strap_bus_clk_freq = 3'h1;
	logic [1:0] strap_reg_map = 2'h1;
	logic [15:0] rx_pkt_len = 16'h0;
	logic eeprom_chip_select_r, eeprom_serial_clock_r, eeprom_data_in_r;
	logic autoload_busy_r, net_disable_r, loopback_digital_r;
	logic tx_media_enable_r, tx_append_fcs_r, tx_burst_unlimited_r;
	logic multi_early_irq_enable_r, rx_whole_packet_r, rx_burst_unlimited_r;
	logic rx_pkt_done_r, rx_pkt_accept_r, rx_crc_checked_r;
	logic [10:0] tx_burst_bytes_r, rx_threshold_bytes_r, rx_burst_bytes_r;
	mtxc_mode_t operating_mode_field_r;
	int num_errors = 0, checks = 0;
	// Flags: crc, align, collided, bcast, mcast, phys
	mtxc_row_t rows [15] = '{
		'{32'h08, 16'd100, 6'b000100, 1'b1, 1'b1},
		'{32'h00, 16'd100, 6'b000100, 1'b0, 1'b1},
		'{32'h04, 16'd64, 6'b000010, 1'b1, 1'b0},
		'{32'h02, 16'd100, 6'b100001, 1'b0, 1'b1},
		'{32'h22, 16'd100, 6'b100001, 1'b1, 1'b1},
		'{32'h01, 16'd100, 6'b000000, 1'b1, 1'b1},
		'{32'h12, 16'd20, 6'b000001, 1'b1, 1'b1},
		'{32'h12, 16'd7, 6'b000001, 1'b0, 1'b0},
		'{32'h02, 16'd20, 6'b000001, 1'b0, 1'b0},
		'{32'h10002, 16'd9, 6'b000001, 1'b0, 1'b1},
		'{32'h10002, 16'd8, 6'b000001, 1'b0, 1'b0},
		'{32'h02, 16'd100, 6'b010001, 1'b0, 1'b1},
		'{32'h22, 16'd100, 6'b001001, 1'b1, 1'b1},
		'{32'h02, 16'd64, 6'b100001, 1'b1, 1'b0},
		'{32'h04, 16'd100, 6'b000110, 1'b0, 1'b1}};
	mtxc_top #(.AUTOLOAD_CYCLES(8)) u_mtxc_top (.core_clk, .rst_n, .reg_addr,
		.reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .transmit_enable,
		.strap_eeprom_large, .strap_boot_rom_size, .strap_aux_power,
		.strap_bus_64bit, .strap_bus_clk_freq, .strap_reg_map, .eeprom_data_out,
		.eeprom_chip_select_r, .eeprom_serial_clock_r, .eeprom_data_in_r,
		.operating_mode_field_r, .autoload_busy_r, .net_disable_r,
		.loopback_digital_r, .tx_media_enable_r, .tx_append_fcs_r,
		.tx_burst_bytes_r, .tx_burst_unlimited_r, .multi_early_irq_enable_r,
		.rx_threshold_bytes_r, .rx_whole_packet_r, .rx_burst_bytes_r,
		.rx_burst_unlimited_r, .rx_pkt_valid, .rx_pkt_len, .rx_crc_err,
		.rx_align_err, .rx_collided, .rx_dst_bcast, .rx_dst_mcast, .rx_dst_phys,
		.rx_pkt_done_r, .rx_pkt_accept_r, .rx_crc_checked_r);
	always #10 core_clk = ~core_clk;
	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_be <= b;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Decoded outputs land one edge after the register
		repeat (2) @(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge core_clk);
		reg_addr <= a;
		// Command word reads are masked by the byte enables
		reg_be <= 4'hf;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		q = reg_rdata_r;
	endtask
	task automatic pk(input logic [15:0] n, input logic [5:0] f);
		@(posedge core_clk);
		rx_pkt_len <= n;
		{rx_crc_err, rx_align_err, rx_collided, rx_dst_bcast, rx_dst_mcast,
			rx_dst_phys} <= f;
		rx_pkt_valid <= 1'b1;
		@(posedge core_clk);
		rx_pkt_valid <= 1'b0;
		@(negedge core_clk);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		stop_test;
	end
	// ==========================================================
	// Tests
	initial begin
		int i;
		logic [31:0] q;
		logic [10:0] e;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		`CHK("fcs", 1'b1, tx_append_fcs_r)
		rd(`MTXC_RX_CFG_OFS, q);
		`CHK("rx_cfg", 32'h0000_0040, q)
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("cmd_cfg", 32'h1104_0501, q)
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			wr(`MTXC_TX_CFG_OFS, 4'hf, (i << 8) | ((i & 3) << 17) | ((i & 1) << 16));
			e = (i == 7) ? 11'h0 : 11'(16 << i);
			`CHK("tx_burst", e, tx_burst_bytes_r)
			`CHK("tx_unl", i == 7, tx_burst_unlimited_r)
			`CHK("lbk", (i & 3) == 1, loopback_digital_r)
			`CHK("media", (i & 3) != 1, tx_media_enable_r)
			`CHK("fcs", !(i & 1), tx_append_fcs_r)
			wr(`MTXC_RX_CFG_OFS, 4'hf, (i << 13) | (i << 8) | ((i & 1) << 24));
			e = (i < 2 || i == 7) ? 11'h0 : 11'(16 << i);
			`CHK("rx_thr", e, rx_threshold_bytes_r)
			`CHK("whole", i == 7, rx_whole_packet_r)
			`CHK("rx_burst", e, rx_burst_bytes_r)
			`CHK("rx_unl", i == 7, rx_burst_unlimited_r)
			`CHK("multi", (i & 1) == 1, multi_early_irq_enable_r)
		end
		$display("test decode done");
		foreach (rows[j]) begin
			wr(`MTXC_RX_CFG_OFS, 4'hf, rows[j].cfg);
			pk(rows[j].len, rows[j].fl);
			`CHK("done", 1'b1, rx_pkt_done_r)
			`CHK("accept", rows[j].acc, rx_pkt_accept_r)
			`CHK("crc_chk", rows[j].crc, rx_crc_checked_r)
		end
		$display("test filter done");
		wr(`MTXC_RX_CFG_OFS, 4'hf, 32'hffff_ffff);
		rd(`MTXC_RX_CFG_OFS, q);
		`CHK("rx_rsvd", 32'h0101_e77f, q)
		@(posedge core_clk);
		transmit_enable <= 1'b0;
		wr(`MTXC_TX_CFG_OFS, 4'hf, 32'h0);
		rd(`MTXC_TX_CFG_OFS, q);
		`CHK("tx_gated", 32'h0007_0700, q)
		@(posedge core_clk);
		transmit_enable <= 1'b1;
		wr(8'h48, 4'hf, 32'hffff_ffff);
		rd(8'h48, q);
		`CHK("unmapped", 32'h0, q)
		wr(`MTXC_EE_CMD_OFS, 4'h4, 32'h00ff_0000);
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("cfg1_lock", 8'h04, q[23:16])
		wr(`MTXC_EE_CMD_OFS, 4'h1, 32'hc0);
		wr(`MTXC_EE_CMD_OFS, 4'he, 32'hffff_ffff);
		@(posedge core_clk);
		strap_aux_power <= 1'b0;
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("cfg_write", 32'h11f7_05c1, q)
		wr(`MTXC_EE_CMD_OFS, 4'h1, 32'h8e);
		`CHK("pins", 3'b111, {eeprom_chip_select_r, eeprom_serial_clock_r,
			eeprom_data_in_r})
		`CHK("net_off", 1'b1, net_disable_r)
		pk(16'd100, 6'b000100);
		`CHK("prog_acc", 1'b0, rx_pkt_accept_r)
		@(posedge core_clk);
		eeprom_data_out <= 1'b0;
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("cmd_prog", 8'h8e, q[7:0])
		wr(`MTXC_EE_CMD_OFS, 4'h1, 32'h0e);
		`CHK("pins_off", 3'b000, {eeprom_chip_select_r, eeprom_serial_clock_r,
			eeprom_data_in_r})
		$display("test access done");
		wr(`MTXC_EE_CMD_OFS, 4'h1, 32'h40);
		`CHK("mode_load", MTXC_MODE_AUTOLOAD, operating_mode_field_r)
		`CHK("busy", 1'b1, autoload_busy_r)
		wr(`MTXC_RX_CFG_OFS, 4'hf, 32'h0000_0008);
		// Still loading here, so the write above must not have landed
		rd(`MTXC_RX_CFG_OFS, q);
		`CHK("load_lock", 32'h0101_e77f, q)
		for (i = 0; i < 40 && operating_mode_field_r !== MTXC_MODE_NORMAL; i++)
			@(negedge core_clk);
		repeat (2) @(negedge core_clk);
		`CHK("mode_back", MTXC_MODE_NORMAL, operating_mode_field_r)
		`CHK("fcs_def", 1'b1, tx_append_fcs_r)
		`CHK("busy_end", 1'b0, autoload_busy_r)
		rd(`MTXC_TX_CFG_OFS, q);
		`CHK("tx_def", 32'h0, q)
		rd(`MTXC_RX_CFG_OFS, q);
		`CHK("rx_def", 32'h0000_0040, q)
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("cmd_def", 32'h1104_0500, q)
		$display("test reload done");
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(negedge core_clk);
		`CHK("rst_fcs", 1'b1, tx_append_fcs_r)
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`MTXC_EE_CMD_OFS, q);
		`CHK("aux_relatch", 8'h01, q[31:24])
		$display("test second reset done");
		stop_test;
	end
endmodule
